// ==== dv/eeprom_read_and_protect_status_test.sv ====
// Bench for the serial memory target: reads and half-array locks.
// Assumes the host model drives the serial link.
`timescale 1ns/100ps
module eeprom_read_and_protect_status_test;
  reg sys_clk = 1'h0;
  reg rst = 1'h1;
  reg wp = 1'h0;
  reg [3:0] pins = 4'h0;
  reg wb_cyc_i = 1'h0;
  reg wb_stb_i = 1'h0;
  reg wb_we_i = 1'h0;
  reg [3:0] wb_adr_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, scl, sda, sda_oe_n;
  integer miscompares = 0;
  integer num_checks = 0;
  reg a;
  reg [31:0] q;
  eeprom_target #(.DEVICE_TYPE(4'h9)) i_dut (.sys_clk(sys_clk), .rst(rst), .scl(scl),
    .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n), .write_protect(wp),
    .strap_bit_low(pins[0]), .strap_bit_mid(pins[1]), .strap_bit_high(pins[2]),
    .high_voltage_level(pins[3]), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  i2c_host_model i_host (.scl(scl), .sda(sda), .sda_oe_n(sda_oe_n));
  initial
    forever #5 sys_clk = ~sys_clk;
  task close_out;
  begin
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input [47:0] w, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %0s exp %h got %h", w, e, g);
    end
  end
  endtask
  task wb(input w, input [3:0] ad, input [31:0] d);
    integer n;
  begin
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    n = 0;
    // Values read right after the edge are those the edge sampled
    @(posedge sys_clk);
    while (wb_ack_o !== 1'h1)
    begin
      n = n + 1;
      if (n > 9)
      begin
        miscompares = miscompares + 1;
        close_out;
      end
      @(posedge sys_clk);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  end
  endtask
  task flags(input [31:0] e);
  begin
    wb(1'h0, 4'h4, 32'h0);
    chk("flags", e, {30'h0, q[1:0]});
  end
  endtask
  task cfg(input p, input [3:0] v);
  begin
    @(posedge sys_clk);
    wp <= p;
    pins <= v;
    repeat (4) @(posedge sys_clk);
  end
  endtask
  function [7:0] mem(input rw);
    mem = {4'h9, pins[2:0], rw};
  endfunction
  task lock(input [7:0] c, input [31:0] e);
    reg [7:0] d;
  begin
    i_host.start;
    i_host.wbyte(c, a);
    if (a && !c[0])
    begin
      i_host.wbyte(8'h0, d[0]);
      i_host.wbyte(8'h0, d[0]);
    end
    if (a && c[0])
      i_host.rbyte(1'h1, d);
    i_host.stop;
    chk("ack", e, {31'h0, a});
  end
  endtask
  task mw(input [7:0] ad, input [15:0] d);
  begin
    i_host.start;
    i_host.wbyte(mem(1'h0), a);
    i_host.wbyte(ad, a);
    i_host.wbyte(d[15:8], a);
    i_host.wbyte(d[7:0], a);
    i_host.stop;
    chk("wrack", 32'h1, {31'h0, a});
  end
  endtask
  task rd(input [7:0] ad, input [23:0] e);
    reg [23:0] g;
  begin
    i_host.start;
    i_host.wbyte(mem(1'h0), a);
    i_host.wbyte(ad, a);
    i_host.start;
    i_host.wbyte(mem(1'h1), a);
    i_host.rbyte(1'h0, g[23:16]);
    i_host.rbyte(1'h0, g[15:8]);
    i_host.rbyte(1'h1, g[7:0]);
    i_host.stop;
    chk("seqrd", {8'h0, e}, {8'h0, g});
  end
  endtask
  task t_regs;
  begin
    wb(1'h0, 4'h4, 32'h0);
    chk("status", 32'h0, q);
    wb(1'h0, 4'h8, 32'h0);
    chk("unmap", 32'h0, q);
    wb(1'h1, 4'h0, 32'h0);
    lock(mem(1'h1), 32'h0);
    wb(1'h1, 4'h0, 32'h1);
  end
  endtask
  task t_reads;
    reg [7:0] g;
  begin
    mw(8'hfe, 16'ha1b2);
    mw(8'h00, 16'hc3d4);
    rd(8'hfe, 24'ha1b2c3);
    i_host.start;
    i_host.wbyte(mem(1'h1), a);
    i_host.rbyte(1'h1, g);
    i_host.stop;
    chk("cur", 32'hd4, {24'h0, g});
    wb(1'h0, 4'h4, 32'h0);
    chk("count", 32'h2, {24'h0, q[15:8]});
  end
  endtask
  task t_rev;
  begin
    cfg(1'h0, 4'h9);
    lock(8'h63, 32'h1);
    lock(8'h62, 32'h1);
    flags(32'h2);
    lock(8'h63, 32'h0);
    lock(8'h62, 32'h0);
    mw(8'h00, 16'h1122);
    mw(8'hfe, 16'he5f6);
    rd(8'hfe, 24'he5f6c3);
    cfg(1'h1, 4'hb);
    lock(8'h66, 32'h1);
    flags(32'h2);
    cfg(1'h0, 4'hb);
    lock(8'h66, 32'h1);
    flags(32'h0);
  end
  endtask
  task t_hw;
  begin
    cfg(1'h1, 4'h9);
    mw(8'hfe, 16'h0);
    mw(8'h00, 16'h0);
    rd(8'hfe, 24'he5f6c3);
    lock(8'h62, 32'h1);
    cfg(1'h1, 4'h2);
    lock(8'h64, 32'h1);
    flags(32'h0);
  end
  endtask
  task t_perm;
  begin
    cfg(1'h0, 4'h2);
    lock(8'h65, 32'h1);
    lock(8'h64, 32'h1);
    flags(32'h1);
    lock(8'h65, 32'h0);
    lock(8'h64, 32'h0);
    mw(8'h00, 16'h9999);
    cfg(1'h0, 4'hb);
    lock(8'h66, 32'h0);
    flags(32'h1);
    rd(8'hfe, 24'he5f6c3);
  end
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    t_regs;
    t_reads;
    t_rev;
    t_hw;
    t_perm;
    close_out;
  end
endmodule // eeprom_read_and_protect_status_test

// ==== dv/eeprom_target_monitor.sv ====
// Port checker for the serial memory target.
// Assumes it is bound onto eeprom_target.
`timescale 1ns/100ps
module eeprom_target_monitor (
  input wire sys_clk,
  input wire rst,
  input wire scl,
  input wire sda_out,
  input wire sda_oe_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o
);
  reg [4:0] scl_hi;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Cycles the link clock has stayed high
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst || !scl)
      scl_hi <= 5'h0;
    else if (scl_hi != 5'h1f)
      scl_hi <= scl_hi + 5'h1;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next_pulse: assert property (s_req |=> s_pulse)
    else $error("ack missing after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) > 4'h4
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_sda_only_low: assert property (sda_out == 1'h0)
    else $error("data line driven high");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data changed while clock high");
  a_drive_bounded: assert property (!sda_oe_n |-> scl_hi < 5'hc)
    else $error("data held past clock high");
endmodule // eeprom_target_monitor

bind eeprom_target eeprom_target_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .scl(scl),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// ==== dv/i2c_host_model.sv ====
// Two-wire bus master model, 125 ns bit period.
// Assumes a pull-up on the data line.
`timescale 1ns/100ps
module i2c_host_model (
  output reg scl,
  output wire sda,
  input wire sda_oe_n
);
  reg sda_drv_n;
  assign sda = sda_drv_n & sda_oe_n;
  initial
  begin
    scl = 1'h1;
    sda_drv_n = 1'h1;
  end
  task bit_io(input b, output s);
  begin
    sda_drv_n = b;
    #31.2;
    scl = 1'h1;
    #31.2;
    s = sda;
    #31.2;
    scl = 1'h0;
    #31.4;
  end
  endtask
  task start;
  begin
    sda_drv_n = 1'h1;
    #31.2;
    scl = 1'h1;
    #31.2;
    sda_drv_n = 1'h0;
    #31.2;
    scl = 1'h0;
    #31.2;
  end
  endtask
  task stop;
  begin
    sda_drv_n = 1'h0;
    #31.2;
    scl = 1'h1;
    #31.2;
    sda_drv_n = 1'h1;
    #62.4;
  end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    reg s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_io(d[i], s);
    bit_io(1'h1, s);
    ack = !s;
  end
  endtask
  task rbyte(input last, output [7:0] d);
    integer i;
    reg s;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_io(1'h1, s);
      d[i] = s;
    end
    bit_io(last, s);
  end
  endtask
endmodule // i2c_host_model

// ==== hdl/eeprom_target.v ====
// Target-side two-wire serial logic of a 256-byte memory with half-array locks.
// Assumes SCL and SDA arrive from another clock domain and are oversampled by
// sys_clk; SDA is open drain, driven low only while sda_oe_n is low.
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "eeprom_target_regs.vh"

module eeprom_target #(
  parameter [3:0] DEVICE_TYPE = 4'hb, // Arbitrary value
  parameter ADDR_W = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire write_protect,
  input wire strap_bit_low,
  input wire strap_bit_mid,
  input wire strap_bit_high,
  input wire high_voltage_level,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  localparam S_IDLE = 6'b000001;
  localparam S_RX = 6'b000010;
  localparam S_ACK = 6'b000100;
  localparam S_TX = 6'b001000;
  localparam S_MACK = 6'b010000;
  localparam S_WAIT = 6'b100000;

  localparam C_NONE = 3'h0;
  localparam C_PERM_SET = 3'h1;
  localparam C_PERM_QUERY = 3'h2;
  localparam C_REV_SET = 3'h3;
  localparam C_REV_QUERY = 3'h4;
  localparam C_REV_CLEAR = 3'h5;

  reg [7:0] mem [0:(1 << ADDR_W) - 1];

  // Two-stage synchronisers for the link, protect, strap and high-voltage pins
  reg [6:0] sync1;
  reg [6:0] sync2;
  reg scl_d;
  reg sda_d;

  reg [5:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [1:0] idx;
  reg is_mem;
  reg rd_dir;
  reg [2:0] cmd;
  reg give_ack;
  reg master_ack;
  reg [ADDR_W-1:0] addr_cnt;
  reg perm_flag;
  reg rev_flag;
  reg enable;

  wire scl_s = sync2[0];
  wire sda_s = sync2[1];
  wire wp_s = sync2[2];
  wire [2:0] straps = sync2[5:3];
  wire hv_s = sync2[6];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Write increment stays within a page
  function [ADDR_W-1:0] page_inc;
    input [ADDR_W-1:0] a;
    begin
      page_inc = {a[ADDR_W-1:`PAGE_BITS], a[`PAGE_BITS-1:0] + 1'b1};
    end
  endfunction

  function writable;
    input [ADDR_W-1:0] a;
    input wp;
    input pf;
    input rf;
    begin
      writable = ~wp & (a[`HALF_BIT] | ~(pf | rf));
    end
  endfunction

  // Decode of a complete control byte
  reg [2:0] next_cmd;
  reg next_is_mem;
  reg next_ack;
  always @*
  begin
    next_cmd = C_NONE;
    next_is_mem = 1'b0;
    next_ack = 1'b0;
    if (shreg[7:4] == DEVICE_TYPE && shreg[3:1] == straps)
    begin
      next_is_mem = 1'b1;
      next_ack = 1'b1;
    end
    else if (shreg[7:4] == `PROT_PREAMBLE)
    begin
      if (hv_s && shreg[3:1] == `REV_SET_BITS && straps[2:1] == 2'b00)
        next_cmd = (shreg[0] == `DIR_READ) ? C_REV_QUERY : C_REV_SET;
      else if (hv_s && shreg[3:1] == `REV_CLEAR_BITS && straps[2:1] == 2'b01 && !shreg[0])
        next_cmd = C_REV_CLEAR;
      else if (shreg[3:1] == straps)
        next_cmd = (shreg[0] == `DIR_READ) ? C_PERM_QUERY : C_PERM_SET;
      case (next_cmd)
        C_PERM_SET: next_ack = ~perm_flag;
        C_PERM_QUERY: next_ack = ~perm_flag;
        C_REV_SET: next_ack = ~rev_flag;
        C_REV_QUERY: next_ack = ~rev_flag;
        C_REV_CLEAR: next_ack = ~perm_flag;
        default: next_ack = 1'b0;
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      // Link clock and data idle high, so no false edge after reset
      sync1 <= 7'h03;
      sync2 <= 7'h03;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      sync1 <= {high_voltage_level, strap_bit_high, strap_bit_mid, strap_bit_low,
                write_protect, sda_in, scl};
      sync2 <= sync1;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Array write port
  always @(posedge sys_clk)
  begin
    if (state == S_RX && scl_fall && bit_cnt == `BITS_PER_BYTE && is_mem && !rd_dir &&
        idx == `IDX_DATA && writable(addr_cnt, wp_s, perm_flag, rev_flag))
      mem[addr_cnt] <= shreg;
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      idx <= 2'h0;
      is_mem <= 1'b0;
      rd_dir <= 1'b0;
      cmd <= C_NONE;
      give_ack <= 1'b0;
      master_ack <= 1'b0;
      addr_cnt <= {ADDR_W{1'b0}};
      perm_flag <= 1'b0;
      rev_flag <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      sda_out <= 1'b0;
      if (stop_cond)
      begin
        state <= S_IDLE;
        sda_oe_n <= 1'b1;
      end
      else if (start_cond && enable)
      begin
        state <= S_RX;
        bit_cnt <= 4'h0;
        idx <= 2'h0;
        sda_oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          S_RX:
          begin
            if (scl_rise && bit_cnt != `BITS_PER_BYTE)
            begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
            begin
              bit_cnt <= 4'h0;
              give_ack <= 1'b1;
              sda_oe_n <= 1'b0;
              state <= S_ACK;
              if (idx == 2'h0)
              begin
                is_mem <= next_is_mem;
                cmd <= next_cmd;
                rd_dir <= shreg[0];
                give_ack <= next_ack;
                sda_oe_n <= ~next_ack;
                if (!next_ack)
                  state <= S_WAIT;
                idx <= `IDX_WORD;
              end
              else if (idx == `IDX_WORD)
              begin
                if (is_mem)
                  addr_cnt <= shreg;
                idx <= `IDX_DATA;
              end
              else if (is_mem)
                addr_cnt <= page_inc(addr_cnt);
              else if (!wp_s && idx == `IDX_DATA)
              begin
                // Locks change only with the protect pin low
                if (cmd == C_PERM_SET)
                  perm_flag <= 1'b1;
                if (cmd == C_REV_SET)
                  rev_flag <= 1'b1;
                if (cmd == C_REV_CLEAR)
                  rev_flag <= 1'b0;
              end
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              if (rd_dir)
              begin
                state <= S_TX;
                if (is_mem)
                begin
                  shreg <= mem[addr_cnt];
                  sda_oe_n <= mem[addr_cnt][7];
                  addr_cnt <= addr_cnt + 1'b1;
                end
                else
                begin
                  shreg <= `FILL_BYTE;
                  sda_oe_n <= 1'b1;
                end
              end
              else
              begin
                state <= S_RX;
                sda_oe_n <= 1'b1;
              end
            end
          end
          S_TX:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == `LAST_BIT)
              begin
                bit_cnt <= 4'h0;
                sda_oe_n <= 1'b1;
                state <= S_MACK;
              end
              else
              begin
                bit_cnt <= bit_cnt + 4'h1;
                shreg <= {shreg[6:0], 1'b1};
                sda_oe_n <= shreg[6];
              end
            end
          end
          S_MACK:
          begin
            if (scl_rise)
              master_ack <= ~sda_s;
            else if (scl_fall)
            begin
              if (master_ack && is_mem)
              begin
                state <= S_TX;
                shreg <= mem[addr_cnt];
                sda_oe_n <= mem[addr_cnt][7];
                addr_cnt <= addr_cnt + 1'b1;
              end
              else if (master_ack)
              begin
                state <= S_TX;
                shreg <= `FILL_BYTE;
              end
              else
                state <= S_WAIT;
            end
          end
          S_WAIT:
            sda_oe_n <= 1'b1;
          S_IDLE:
            sda_oe_n <= 1'b1;
          default:
          begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Wishbone slave: answer one cycle after the request, drop after one
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      enable <= `CTRL_RESET;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `CTRL_OFFSET)
          enable <= wb_dat_i[`CTRL_ENABLE_BIT];
        if (!wb_we_i && wb_adr_i == `CTRL_OFFSET)
          wb_dat_o[`CTRL_ENABLE_BIT] <= enable;
        if (!wb_we_i && wb_adr_i == `STATUS_OFFSET)
        begin
          wb_dat_o[`STATUS_PERM_BIT] <= perm_flag;
          wb_dat_o[`STATUS_REV_BIT] <= rev_flag;
          wb_dat_o[`STATUS_BUSY_BIT] <= (state != S_IDLE);
          wb_dat_o[`STATUS_WP_BIT] <= wp_s;
          wb_dat_o[`STATUS_ADDR_LSB +: ADDR_W] <= addr_cnt;
        end
      end
    end
  end

endmodule // eeprom_target

// ==== inc/eeprom_target_regs.vh ====
// Constants for the two-wire serial memory target and its register window.
// Assumes a byte-lane Wishbone slave with 32-bit data and word-aligned offsets.
`ifndef EEPROM_TARGET_REGS_VH
`define EEPROM_TARGET_REGS_VH

// Register offsets (byte addresses)
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4

// Control fields
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'b1

// Status fields
`define STATUS_PERM_BIT 0
`define STATUS_REV_BIT 1
`define STATUS_BUSY_BIT 2
`define STATUS_WP_BIT 3
`define STATUS_ADDR_LSB 8

// Control byte layout
`define PROT_PREAMBLE 4'h6
`define REV_SET_BITS 3'h1
`define REV_CLEAR_BITS 3'h3
`define DIR_READ 1'b1

// Lower half of the array is the software-protected half
`define HALF_BIT 7
`define PAGE_BITS 4

`define BITS_PER_BYTE 4'h8
`define LAST_BIT 4'h7
`define IDX_DATA 2'h2
`define IDX_WORD 2'h1
`define FILL_BYTE 8'hff

`endif
